/* File: common/rwdt_pkg.sv */
`default_nettype none
package rwdt_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 22;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h01;
  localparam logic [7:0] OFS_STATUS  = 8'h02;

  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int unsigned MODE_ENABLE_BIT     = 7;
  localparam int unsigned MODE_PERIOD_LSB     = 5;
  localparam int unsigned MODE_IDLE_RUN_BIT   = 3;
  localparam int unsigned MODE_RESET_LINK_BIT = 2;

  localparam logic       RST_ENABLE     = 1'b1;
  localparam logic [1:0] RST_PERIOD     = 2'h0;
  localparam logic       RST_IDLE_RUN   = 1'b0;
  localparam logic       RST_RESET_LINK = 1'b0;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int unsigned STAT_OVF_BIT      = 0;
  localparam int unsigned STAT_COUNTING_BIT = 1;
  localparam int unsigned STAT_DISABLED_BIT = 2;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_CLEAR   = 8'h4e;
  localparam logic [7:0] CMD_DISABLE = 8'hb1;

  // ****************************************************************
  // Overflow tap exponents
  // ****************************************************************
  localparam int unsigned TAP_EXP0 = 15;
  localparam int unsigned TAP_EXP1 = 17;
  localparam int unsigned TAP_EXP2 = 19;
  localparam int unsigned TAP_EXP3 = 21;

  // ****************************************************************
  // Internal reset timing
  // ****************************************************************
  localparam int unsigned RESET_STATES_MIN = 22;
  localparam int unsigned RESET_STATES_MAX = 29;
  localparam logic [4:0]  RESET_STATES     = 5'h18;
  localparam logic [3:0]  STATE_CLKS       = 4'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rwdt_bus_req_t;

  typedef struct packed {
    logic stop_mode;
    logic light_halt_mode;
    logic partial_halt_mode;
    logic bus_grant_ack;
  } rwdt_power_t;

  typedef enum logic [2:0] {
    RWDT_RUN      = 3'b001,
    RWDT_DISABLED = 3'b010,
    RWDT_RESETTING = 3'b100
  } rwdt_state_t;

  typedef struct packed {
    rwdt_state_t      st;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       detect_period_sel;
    logic             wdog_enable_bit;
    logic             idle_run_bit;
    logic             reset_link_bit;
    logic             ovf_flag;
    logic             watchdog_nmi;
    logic             start_rst;
    logic [DATA_W-1:0] rdata;
  } rwdt_core_t;

  typedef struct packed {
    logic       active;
    logic       done;
    logic [3:0] pre;
    logic [4:0] states;
  } rwdt_stretch_t;

endpackage : rwdt_pkg
`default_nettype wire

/* File: rtl/rwdt_reset_stretch.sv */
`default_nettype none
module rwdt_reset_stretch (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  output logic      active_q,
  output logic      done_q
);

  rwdt_pkg::rwdt_stretch_t s_q;
  rwdt_pkg::rwdt_stretch_t s_d;

  // ****************************************************************
  // Reset pulse of a fixed number of peripheral states
  // ****************************************************************
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.active) begin
      if (start) begin
        s_d.active = 1'b1;
        s_d.pre    = 4'h0;
        s_d.states = 5'h00;
      end
    end else if (s_q.pre == rwdt_pkg::STATE_CLKS - 4'h1) begin
      s_d.pre = 4'h0;
      if (s_q.states == rwdt_pkg::RESET_STATES - 5'h01) begin
        s_d.active = 1'b0;
        s_d.done   = 1'b1;
      end else begin
        s_d.states = s_q.states + 5'h01;
      end
    end else begin
      s_d.pre = s_q.pre + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign active_q = s_q.active;
  assign done_q   = s_q.done;

endmodule : rwdt_reset_stretch
`default_nettype wire

/* File: rtl/rwdt_top.sv */
// Design decisions made here: the address-and-strobe port and the address map.
`default_nettype none
// Operation
// - An overflow of the counter at the selected period raises the watchdog interrupt.
// - The watchdog interrupt is a non-maskable pulse with no mask in this block.
// - A 22-bit counter on the system clock gives overflow taps at 2^15, 2^17, 2^19 and 2^21.
// - Counting starts right after reset release with no software action.
// - Period select resets to 00, the shortest period.
// - Enable resets to 1 and the watchdog stops only on code B1 written while enable is 0.
// - Writing enable to 1 alone re-enables a disabled watchdog.
// - Code 4E written to the command register zeroes the counter and counting goes on.
// - The counter halts in light halt mode and in stop mode.
// - The counter keeps counting while the bus is released.
// - In partial halt mode the idle run bit decides whether the counter runs.
// - With the reset link bit set an overflow forces an internal reset as well as the interrupt.
// - The reset link bit resets to 0 so an overflow gives no reset by default.
// - The forced internal reset lasts a fixed count of peripheral states within 22 to 29.
module rwdt_top (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire rwdt_pkg::rwdt_bus_req_t       bus_req,
  output logic [rwdt_pkg::DATA_W-1:0]        rdata_q,
  input  wire rwdt_pkg::rwdt_power_t         power,
  output logic                               watchdog_nmi_q,
  output logic                               internal_reset_q,
  output logic                               counting_q
);

  // ****************************************************************
  // State
  // ****************************************************************
  rwdt_pkg::rwdt_core_t c_q;
  rwdt_pkg::rwdt_core_t c_d;
  logic                 stretch_active;
  logic                 stretch_done;
  logic                 counting_d;
  logic                 counting_r;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic tap_reached(
    input logic [rwdt_pkg::CNT_W-1:0] cnt,
    input logic [1:0]                 sel
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      2'h0: hit = &cnt[rwdt_pkg::TAP_EXP0-1:0];
      2'h1: hit = &cnt[rwdt_pkg::TAP_EXP1-1:0];
      2'h2: hit = &cnt[rwdt_pkg::TAP_EXP2-1:0];
      2'h3: hit = &cnt[rwdt_pkg::TAP_EXP3-1:0];
    endcase
    return hit;
  endfunction : tap_reached

  function automatic logic halted(
    input rwdt_pkg::rwdt_power_t pw,
    input logic                  idle_run
  );
    logic h;
    h = 1'b0;
    if (pw.stop_mode || pw.light_halt_mode) begin
      h = 1'b1;
    end else if (pw.partial_halt_mode && !idle_run) begin
      h = 1'b1;
    end
    // Bus grant acknowledge has no effect on counting
    return h;
  endfunction : halted

  function automatic logic [rwdt_pkg::DATA_W-1:0] mode_image(
    input rwdt_pkg::rwdt_core_t c
  );
    logic [rwdt_pkg::DATA_W-1:0] v;
    v = 8'h00;
    v[rwdt_pkg::MODE_ENABLE_BIT]                          = c.wdog_enable_bit;
    v[rwdt_pkg::MODE_PERIOD_LSB +: 2]                     = c.detect_period_sel;
    v[rwdt_pkg::MODE_IDLE_RUN_BIT]                        = c.idle_run_bit;
    v[rwdt_pkg::MODE_RESET_LINK_BIT]                      = c.reset_link_bit;
    return v;
  endfunction : mode_image

  function automatic logic [rwdt_pkg::DATA_W-1:0] status_image(
    input rwdt_pkg::rwdt_core_t c,
    input logic                 cnt_on
  );
    logic [rwdt_pkg::DATA_W-1:0] v;
    v = 8'h00;
    v[rwdt_pkg::STAT_OVF_BIT]      = c.ovf_flag;
    v[rwdt_pkg::STAT_COUNTING_BIT] = cnt_on;
    v[rwdt_pkg::STAT_DISABLED_BIT] = (c.st == rwdt_pkg::RWDT_DISABLED);
    return v;
  endfunction : status_image

  function automatic rwdt_pkg::rwdt_core_t reset_image();
    rwdt_pkg::rwdt_core_t r;
    r                   = '0;
    r.st                = rwdt_pkg::RWDT_RUN;
    r.detect_period_sel = rwdt_pkg::RST_PERIOD;
    r.wdog_enable_bit   = rwdt_pkg::RST_ENABLE;
    r.idle_run_bit      = rwdt_pkg::RST_IDLE_RUN;
    r.reset_link_bit    = rwdt_pkg::RST_RESET_LINK;
    return r;
  endfunction : reset_image

  // ****************************************************************
  // Internal reset stretcher
  // ****************************************************************
  rwdt_reset_stretch u_stretch (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .start    (c_q.start_rst),
    .active_q (stretch_active),
    .done_q   (stretch_done)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic wr_mode;
  logic wr_cmd;
  logic wr_stat;
  logic cmd_clear;
  logic cmd_disable;
  logic overflow;
  logic run;

  always_comb begin
    c_d              = c_q;
    c_d.watchdog_nmi = 1'b0;
    c_d.start_rst    = 1'b0;
    c_d.rdata        = 8'h00;

    wr_mode     = bus_req.wr && (bus_req.addr == rwdt_pkg::OFS_MODE);
    wr_cmd      = bus_req.wr && (bus_req.addr == rwdt_pkg::OFS_COMMAND);
    wr_stat     = bus_req.wr && (bus_req.addr == rwdt_pkg::OFS_STATUS);
    cmd_clear   = wr_cmd && (bus_req.wdata == rwdt_pkg::CMD_CLEAR);
    cmd_disable = wr_cmd && (bus_req.wdata == rwdt_pkg::CMD_DISABLE);

    run      = (c_q.st == rwdt_pkg::RWDT_RUN) && !halted(power, c_q.idle_run_bit);
    overflow = run && tap_reached(c_q.cnt, c_q.detect_period_sel);
    counting_d = 1'b0;

    unique case (c_q.st)
      rwdt_pkg::RWDT_RUN: begin
        counting_d = run;
        if (run) begin
          c_d.cnt = c_q.cnt + 22'h000001;
        end
        if (cmd_clear) begin
          c_d.cnt = '0;
        end
        if (overflow) begin
          c_d.watchdog_nmi = 1'b1;
          if (c_q.reset_link_bit) begin
            c_d.st        = rwdt_pkg::RWDT_RESETTING;
            c_d.start_rst = 1'b1;
          end
        end
        if (cmd_disable && !c_q.wdog_enable_bit && !overflow) begin
          c_d.st = rwdt_pkg::RWDT_DISABLED;
        end
      end
      rwdt_pkg::RWDT_DISABLED: begin
        if (cmd_clear) begin
          c_d.cnt = '0;
        end
        if (wr_mode && bus_req.wdata[rwdt_pkg::MODE_ENABLE_BIT]) begin
          c_d.st = rwdt_pkg::RWDT_RUN;
        end
      end
      rwdt_pkg::RWDT_RESETTING: begin
        c_d.cnt = '0;
      end
      default: begin
        c_d.st = rwdt_pkg::RWDT_RUN;
      end
    endcase

    // Register writes, ignored while the forced reset holds the block
    if (c_q.st != rwdt_pkg::RWDT_RESETTING) begin
      if (wr_mode) begin
        c_d.wdog_enable_bit   = bus_req.wdata[rwdt_pkg::MODE_ENABLE_BIT];
        c_d.detect_period_sel = bus_req.wdata[rwdt_pkg::MODE_PERIOD_LSB +: 2];
        c_d.idle_run_bit      = bus_req.wdata[rwdt_pkg::MODE_IDLE_RUN_BIT];
        c_d.reset_link_bit    = bus_req.wdata[rwdt_pkg::MODE_RESET_LINK_BIT];
      end
      if (wr_stat && bus_req.wdata[rwdt_pkg::STAT_OVF_BIT]) begin
        c_d.ovf_flag = 1'b0;
      end
    end
    // Overflow sets the flag even in the clearing cycle
    if (overflow) begin
      c_d.ovf_flag = 1'b1;
    end

    // Read data for the cycle after the strobe
    if (bus_req.rd) begin
      if (bus_req.addr == rwdt_pkg::OFS_MODE) begin
        c_d.rdata = mode_image(c_q);
      end else if (bus_req.addr == rwdt_pkg::OFS_STATUS) begin
        c_d.rdata = status_image(c_q, counting_r);
      end else begin
        c_d.rdata = 8'h00;
      end
    end

    // End of forced reset returns the block to its reset image with the overflow flag set
    if (c_q.st == rwdt_pkg::RWDT_RESETTING && stretch_done) begin
      c_d          = reset_image();
      c_d.ovf_flag = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      c_q        <= reset_image();
      counting_r <= 1'b0;
    end else if (ce) begin
      c_q        <= c_d;
      counting_r <= counting_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_q          = c_q.rdata;
  assign watchdog_nmi_q   = c_q.watchdog_nmi;
  assign internal_reset_q = stretch_active;
  assign counting_q       = counting_r;

endmodule : rwdt_top
`default_nettype wire

/* File: test/runaway_watchdog_timer_tb.sv */
`default_nettype none
module runaway_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  rwdt_pkg::rwdt_bus_req_t bus_req = '0;
  rwdt_pkg::rwdt_power_t   power = 4'h1;
  logic [7:0]              rdata_q;
  logic                    watchdog_nmi_q;
  logic                    internal_reset_q;
  logic                    counting_q;
  int                      mismatches = 0;
  int                      check_count = 0;
  int                      n;

  always #50 clk = ~clk;

  rwdt_top i_rwdt_top (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rdata_q(rdata_q),
    .power(power), .watchdog_nmi_q(watchdog_nmi_q), .internal_reset_q(internal_reset_q),
    .counting_q(counting_q));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 check(name, rdata_q, exp);
  endtask : rd

  // Apply power levels, then look at the counter activity
  task automatic run_chk(input logic [3:0] p, input logic e);
    @(posedge clk);
    power <= p;
    repeat (3) @(posedge clk);
    #1 check("counting", {7'h00, counting_q}, {7'h00, e});
  endtask : run_chk

  task automatic wait_nmi();
    n = 0;
    while (watchdog_nmi_q !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1 n++;
    end
    check("nmi delay", {7'h00, n >= 32767 && n <= 32771}, 8'h01);
  endtask : wait_nmi

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #10000000;
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    run_chk(4'h1, 1'b1);
    rd(rwdt_pkg::OFS_MODE, 8'h80, "mode");
    rd(rwdt_pkg::OFS_COMMAND, 8'h00, "command");
    rd(8'h3c, 8'h00, "unmapped");
    // Writes taken while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(rwdt_pkg::OFS_MODE, 8'h00);
    ce <= 1'b1;
    rd(rwdt_pkg::OFS_MODE, 8'h80, "frozen mode");
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_DISABLE);
    run_chk(4'h1, 1'b1);
    run_chk(4'h9, 1'b0);
    run_chk(4'h5, 1'b0);
    run_chk(4'h3, 1'b0);
    run_chk(4'h0, 1'b1);
    wr(rwdt_pkg::OFS_MODE, 8'h00);
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_CLEAR);
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_DISABLE);
    wr(rwdt_pkg::OFS_MODE, 8'h68);
    run_chk(4'h1, 1'b0);
    rd(rwdt_pkg::OFS_STATUS, 8'h04, "status");
    rd(rwdt_pkg::OFS_MODE, 8'h68, "mode");
    wr(rwdt_pkg::OFS_MODE, 8'h88);
    run_chk(4'h3, 1'b1);
    run_chk(4'h1, 1'b1);
    // Mid-period clear must push the overflow out
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_CLEAR);
    repeat (20000) @(posedge clk);
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_CLEAR);
    wait_nmi();
    repeat (60) @(posedge clk);
    #1 check("internal reset", {7'h00, internal_reset_q}, 8'h00);
    rd(rwdt_pkg::OFS_STATUS, 8'h03, "status");
    wr(rwdt_pkg::OFS_STATUS, 8'h01);
    rd(rwdt_pkg::OFS_STATUS, 8'h02, "status clear");
    wr(rwdt_pkg::OFS_MODE, 8'h00);
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_CLEAR);
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_DISABLE);
    wr(rwdt_pkg::OFS_MODE, 8'h04);
    rd(rwdt_pkg::OFS_MODE, 8'h04, "mode");
    wr(rwdt_pkg::OFS_MODE, 8'h84);
    // Counter kept its pre-disable count, so restart the period
    wr(rwdt_pkg::OFS_COMMAND, rwdt_pkg::CMD_CLEAR);
    wait_nmi();
    n = 0;
    while (internal_reset_q !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    while (internal_reset_q === 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    check("reset length", {7'h00, n >= 44 && n <= 58}, 8'h01);
    rd(rwdt_pkg::OFS_MODE, 8'h80, "mode");
    wrap_up();
  end
endmodule : runaway_watchdog_timer_tb
`default_nettype wire

/* File: test/rwdt_checker.sv */
`default_nettype none
module rwdt_checker (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          ce,
  input wire rwdt_pkg::rwdt_bus_req_t       bus_req,
  input wire logic [rwdt_pkg::DATA_W-1:0]   rdata_q,
  input wire rwdt_pkg::rwdt_power_t         power,
  input wire logic                          watchdog_nmi_q,
  input wire logic                          internal_reset_q,
  input wire logic                          counting_q
);
  logic [31:0] gap_q;
  logic [31:0] len_q;

  // Cycles since the last clear, overflow or reset
  always_ff @(posedge clk) begin
    if (rst || watchdog_nmi_q || (ce && bus_req.wr && bus_req.addr == rwdt_pkg::OFS_COMMAND
        && bus_req.wdata == rwdt_pkg::CMD_CLEAR)) begin
      gap_q <= 32'h0;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end

  // Length of the current forced reset
  always_ff @(posedge clk) begin
    len_q <= internal_reset_q ? len_q + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  read_idle_a: assert property ($past(ce) && !$past(bus_req.rd) |-> rdata_q == 8'h00)
    else $error("read data not zero outside a read");
  nmi_pulse_a: assert property (watchdog_nmi_q && ce |=> !watchdog_nmi_q)
    else $error("watchdog interrupt longer than one cycle");
  halt_stop_a: assert property (ce && (power.stop_mode || power.light_halt_mode) |=> !counting_q)
    else $error("counter advanced in a halt mode");
  start_count_a: assert property ($fell(rst) && ce && !power.stop_mode && !power.light_halt_mode
      && !power.partial_halt_mode |=> counting_q)
    else $error("counter idle after reset release");
  reset_cause_a: assert property ($rose(internal_reset_q) |-> $past(watchdog_nmi_q))
    else $error("forced reset without an overflow");
  reset_len_a: assert property ($fell(internal_reset_q) |-> len_q >= 32'd44 && len_q <= 32'd58)
    else $error("forced reset length out of range");
  period_floor_a: assert property (watchdog_nmi_q |-> gap_q >= 32'd32767)
    else $error("overflow before the shortest period");
  freeze_hold_a: assert property (!ce |=> $stable(counting_q) && $stable(internal_reset_q))
    else $error("state moved with clock enable low");

  cover property (watchdog_nmi_q);
  cover property ($fell(internal_reset_q));
  cover property (power.partial_halt_mode && counting_q);
endmodule : rwdt_checker

bind rwdt_top rwdt_checker i_rwdt_checker (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req),
  .rdata_q(rdata_q), .power(power), .watchdog_nmi_q(watchdog_nmi_q),
  .internal_reset_q(internal_reset_q), .counting_q(counting_q));
`default_nettype wire
